// [bench/rsw_modem_model.sv]
// Behavioural bank of traffic modems and the spare modem facing the switch.
`timescale 1ns/10ps
module rsw_modem_model (
	input  wire logic                       sys_clk,
	input  wire logic [rsw_pkg::NSLOT-1:0]  txF,
	input  wire logic [rsw_pkg::NSLOT-1:0]  rxF,
	input  wire logic [rsw_pkg::NSLOT-1:0]  almF,
	input  wire logic                       rmBad,
	input  wire logic                       rpt,
	input  wire logic [3:0]                 rptSlot,
	input  wire logic                       rmLoad,
	input  wire logic [31:0]                rmCfg,
	output rsw_pkg::rsw_mdm_t               mdm,
	output logic                            rmFault,
	output logic                            learnValid,
	output logic [3:0]                      learnSlot,
	output logic [31:0]                     learnCfg,
	output logic [31:0]                     loadedCfg
);
	import rsw_pkg::*;
	// Each modem reports its own slot number in its configuration word.
	always_ff @(posedge sys_clk) begin
		mdm        <= '{alarm: almF, rx: rxF, tx: txF};
		rmFault    <= rmBad;
		learnValid <= rpt;
		learnSlot  <= rptSlot;
		learnCfg   <= {28'hc0f0000, rptSlot};
		if (rmLoad === 1'b1) begin
			loadedCfg <= rmCfg;
		end
	end
endmodule

// [bench/tb_rsw_switch_ctrl.sv]
// Self-checking bench of the redundancy switchover controller.
`timescale 1ns/10ps
module tb_rsw_switch_ctrl;
	import rsw_pkg::*;
	logic              sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, panelAccess;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, learnCfg, rmCfg, loadedCfg, r;
	rsw_mdm_t          mdm;
	logic              rmFault, rmBad, first_supply_unit, second_supply_unit, learnValid, rpt;
	logic [3:0]        learnSlot, rptSlot, bridgeSel, logSlot;
	logic              rmOnline, rmLoad, buzzer, alarmRelay, storedEventLed, logValid, ledQ;
	logic [1:0]        logKind;
	logic [2:0]        baudSel;
	logic [15:0]       busAddr;
	logic [NSLOT-1:0]  txF, rxF, almF;
	logic [5:0]        lastLog;
	int                n_mismatch, checks_done, nlog, flips;

	rsw_switch_ctrl #(.TICK_CYCLES(20)) i_dut (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .panelAccess, .mdm, .rmFault, .first_supply_unit,
		.second_supply_unit, .learnValid, .learnSlot, .learnCfg, .bridgeSel, .rmOnline, .rmLoad,
		.rmCfg, .buzzer, .alarmRelay, .storedEventLed, .logValid, .logSlot, .logKind, .baudSel, .busAddr);
	rsw_modem_model i_bank (.sys_clk, .txF, .rxF, .almF, .rmBad, .rpt, .rptSlot, .rmLoad, .rmCfg,
		.mdm, .rmFault, .learnValid, .learnSlot, .learnCfg, .loadedCfg);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (logValid === 1'b1) begin
			nlog++;
			lastLog <= {logKind, logSlot};
		end
		if (storedEventLed !== ledQ) begin
			flips++;
		end
		ledQ <= storedEventLed;
	end

	// ************************************************************
	// Bus and comparison tasks
	// ************************************************************
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			wrap_up();
		end
		r = prdata;
		chk("pslverr", {31'h0, e}, {31'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0, 1'b0);
		chk("read", e, r & m);
	endtask

	// Waits for rmOnline (s=0) or bridgeSel (s=1) to reach v.
	task automatic waitv(input logic s, input logic [3:0] v);
		int k;
		for (k = 0; k < 300; k++) begin
			@(posedge sys_clk);
			if ((s ? bridgeSel : {3'h0, rmOnline}) === v) break;
		end
		if (k == 300) begin
			n_mismatch++;
			wrap_up();
		end
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rmBad, rpt, rptSlot} = '0;
		{first_supply_unit, second_supply_unit, txF, rxF, almF} = '0;
		{n_mismatch, checks_done, nlog, flips} = '0;
		panelAccess = 1'b1;
		sys_rst = 1'b1;
		cyc(6);
		sys_rst <= 1'b0;
		chk("baudSel", 32'h4, {29'h0, baudSel});
		rd(A_STAT, 32'h100, 32'h1f7f);
		rd(A_HOLD, 32'h0a05, 32'hffffffff);
		panelAccess <= 1'b0;
		apb(1'b1, A_ACT, 32'h0c, 1'b1);
		rd(A_STAT, 32'h100, 32'h1f7f);
		panelAccess <= 1'b1;
		apb(1'b1, A_ACT, 32'h0c, 1'b0);
		cyc(3);
		chk("bridgeSel", 32'h2, {28'h0, bridgeSel});
		rpt <= 1'b1;
		rptSlot <= 4'h2;
		cyc(1);
		rptSlot <= 4'h3;
		cyc(1);
		rpt <= 1'b0;
		apb(1'b1, A_SEL, 32'h3, 1'b0);
		cyc(3);
		chk("loadedCfg", 32'hc0f00003, loadedCfg);
		apb(1'b1, A_SEL, 32'h4, 1'b1);
		apb(1'b1, A_SEL, 32'h203, 1'b0);
		cyc(2);
		chk("bridgeSel", 32'h2, {28'h0, bridgeSel});
		apb(1'b1, A_PRIO, 32'h15, 1'b1);
		apb(1'b1, A_PRIO, 32'h13, 1'b0);
		apb(1'b1, A_HOLD, 32'h0a00, 1'b1);
		apb(1'b1, A_HOLD, 32'h0a64, 1'b1);
		apb(1'b1, A_HOLD, 32'h6301, 1'b0);
		rd(A_HOLD, 32'h6301, 32'hffffffff);
		apb(1'b1, A_HOLD, 32'h0202, 1'b0);
		apb(1'b1, A_CTRL, 32'h430, 1'b1);
		apb(1'b1, A_CTRL, 32'h600, 1'b1);
		apb(1'b1, A_ADDR, 32'h3000, 1'b0);
		apb(1'b1, A_CTRL, 32'hd00, 1'b0);
		cyc(2);
		chk("baudSel", 32'h5, {29'h0, baudSel});
		chk("busAddr", 32'h0, {16'h0, busAddr});
		apb(1'b1, A_ADDR, 32'h5000, 1'b1);
		apb(1'b1, A_CTRL, 32'h540, 1'b0);
		first_supply_unit <= 1'b1;
		cyc(3);
		chk("buzzer", 32'h1, {31'h0, buzzer});
		chk("alarmRelay", 32'h1, {31'h0, alarmRelay});
		apb(1'b1, A_CTRL, 32'h550, 1'b0);
		cyc(3);
		chk("buzzer", 32'h0, {31'h0, buzzer});
		first_supply_unit <= 1'b0;
		apb(1'b1, A_CTRL, 32'h500, 1'b0);
		nlog = 0;
		flips = 0;
		txF <= 10'h024;
		cyc(100);
		chk("rmOnline", 32'h0, {31'h0, rmOnline});
		chk("nlog", 32'h1, nlog);
		chk("lastLog", 32'h12, {26'h0, lastLog});
		chk("ledMoved", 32'h1, {31'h0, flips > 0});
		txF <= '0;
		apb(1'b1, A_CTRL, 32'h505, 1'b0);
		nlog = 0;
		txF <= 10'h008;
		almF <= 10'h008;
		cyc(100);
		chk("rmOnline", 32'h0, {31'h0, rmOnline});
		chk("nlog", 32'h0, nlog);
		chk("led", 32'h0, {31'h0, storedEventLed});
		{txF, almF} <= '0;
		rxF <= 10'h008;
		waitv(1'b1, 4'h3);
		chk("rmOnline", 32'h0, {31'h0, rmOnline});
		waitv(1'b0, 4'h1);
		apb(1'b1, A_SEL, 32'h2, 1'b1);
		rxF <= '0;
		cyc(100);
		chk("rmOnline", 32'h1, {31'h0, rmOnline});
		rxF <= 10'h004;
		waitv(1'b0, 4'h0);
		waitv(1'b1, 4'h2);
		waitv(1'b0, 4'h1);
		rxF <= 10'h00c;
		waitv(1'b0, 4'h0);
		waitv(1'b1, 4'h3);
		waitv(1'b0, 4'h1);
		apb(1'b1, A_CTRL, 32'h507, 1'b0);
		apb(1'b1, A_HOLD, 32'h0303, 1'b1);
		rd(A_STAT, 32'h23, 32'h3f);
		panelAccess <= 1'b0;
		apb(1'b1, A_HOLD, 32'h0303, 1'b0);
		rd(A_HOLD, 32'h0303, 32'hffffffff);
		apb(1'b1, 8'h1c, 32'h0, 1'b1);
		apb(1'b1, A_STAT, 32'h0, 1'b1);
		wrap_up();
	end
endmodule

// [hdl/rsw_sec_tick.sv]
// One-second tick divider for the holdoff counters and the blink.
`timescale 1ns/10ps
module rsw_sec_tick #(
	parameter int TICK_CYCLES = rsw_pkg::TICK_CYC
) (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	output logic      tick
);
	import rsw_pkg::*;

	logic [23:0] cnt;
	logic [23:0] next_cnt;
	logic        next_tick;

	always_comb begin
		next_cnt = cnt + 24'h000001;
		next_tick = 1'b0;
		if (cnt == 24'(TICK_CYCLES - 1)) begin
			next_cnt = 24'h000000;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt <= 24'h000000;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule

// [hdl/rsw_switch_ctrl.sv]
// Redundancy switchover control with APB register access.
//
// Functional notes
// - Remote monitoring always; local mode: panel writes only.
// - Remote mode: remote bus writes, panel only the remote bit.
// - Manual mode selects bridge/backup; steps skip inactive.
// - Auto mode refuses backup selection, allows bridge.
// - While online, refuse bridge changes; manual mode may only release backup.
// - Store modem configs; load on bridge.
// - Manual mode: no automatic switching on faults.
// - Manual mode blinks stored-event indicator.
// - Switching reacts to faults, never alarms.
// - Failed priority link preempts a non-priority backup.
// - Only active slots may be priority.
// - Backup and restore holdoffs, 1 to 99 s.
// - Holdoffs apply only in auto mode.
// - Bridge faulted modem, check spare, wait backup holdoff.
// - Restore after another faults and restore holdoff.
// - Modem fault mask none/tx/rx/both, gates switching, logging.
// - Mask global; log only active modems.
// - Switch mask none/first/second supply, never both.
// - Audio selection drives buzzer and alarm relay.
// - Remote baud among six rates only.
// - Only active modems eligible for bridge/backup.
// - Single-ended standard forces bus address zero.
`timescale 1ns/10ps
module rsw_switch_ctrl #(
	parameter int TICK_CYCLES = rsw_pkg::TICK_CYC
) (
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  panelAccess,
	input  wire rsw_pkg::rsw_mdm_t     mdm,
	input  wire logic                  rmFault,
	input  wire logic                  first_supply_unit,
	input  wire logic                  second_supply_unit,
	input  wire logic                  learnValid,
	input  wire logic [3:0]            learnSlot,
	input  wire logic [31:0]           learnCfg,
	output logic      [3:0]            bridgeSel,
	output logic                       rmOnline,
	output logic                       rmLoad,
	output logic      [31:0]           rmCfg,
	output logic                       buzzer,
	output logic                       alarmRelay,
	output logic                       storedEventLed,
	output logic                       logValid,
	output logic      [3:0]            logSlot,
	output logic      [1:0]            logKind,
	output logic      [2:0]            baudSel,
	output logic      [15:0]           busAddr
);
	import rsw_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [3:0] lowest(input logic [NSLOT-1:0] m);
		lowest = 4'h0;
		for (int i = NSLOT - 1; i >= 0; i--) begin
			if (m[i]) begin
				lowest = 4'(i);
			end
		end
	endfunction

	function automatic logic [3:0] nextAct(input logic [NSLOT-1:0] m, input logic [3:0] cur);
		int j;
		nextAct = cur;
		for (int k = NSLOT; k >= 1; k--) begin
			j = (int'(cur) + k) % NSLOT;
			if (m[j]) begin
				nextAct = 4'(j);
			end
		end
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	rsw_ctrl_t        ctrl, next_ctrl;
	rsw_state_t       state, next_state;
	logic [NSLOT-1:0] active, next_active, effPrev, next_effPrev;
	logic [3:0]       prio, next_prio, next_bridge, next_logSlot;
	logic             prioEn, next_prioEn, next_online, next_logValid;
	logic [6:0]       holdBk, next_holdBk, holdRs, next_holdRs, cnt, next_cnt;
	logic [15:0]      addr, next_addr;
	logic [31:0]      next_prdata, next_rmCfg, rdMux;
	logic [1:0]       next_logKind;
	logic             next_buzzer, next_blink, next_load, tick;
	logic [31:0]      cfgMem [NSLOT];
	logic [NSLOT-1:0] eff, newF, others;
	logic             wr, srcOk, err, swAlm, mdmAlm;
	logic [6:0]       wBk, wRs;

	rsw_sec_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.tick    (tick)
	);

	// Effective faults: masked types and inactive slots drop out, alarms never count.
	assign eff = ((mdm.tx & {NSLOT{~ctrl.modemMask[0]}}) | (mdm.rx & {NSLOT{~ctrl.modemMask[1]}})) & active;
	assign newF = eff & ~effPrev;
	assign others = eff & ~(NSLOT'(1) << bridgeSel);
	assign wr = psel & penable & pwrite;
	assign srcOk = ctrl.remote ^ panelAccess;
	assign wBk = pwdata[6:0];
	assign wRs = pwdata[HOLD_RS +: 7];
	assign pready = 1'b1;
	assign swAlm = (first_supply_unit & ctrl.swMask != SWM_A) | (second_supply_unit & ctrl.swMask != SWM_B) | rmFault;
	assign mdmAlm = (|eff) | (|(mdm.alarm & active));

	always_comb begin
		case (paddr)
			A_CTRL: rdMux = 32'(ctrl);
			A_ACT: rdMux = 32'(active);
			A_SEL: rdMux = {22'h000000, 1'b0, rmOnline, 4'h0, bridgeSel};
			A_PRIO: rdMux = {27'h0000000, prioEn, prio};
			A_HOLD: rdMux = {17'h00000, holdRs, 1'b0, holdBk};
			A_ADDR: rdMux = {16'h0000, busAddr};
			A_STAT: rdMux = {16'h0000, 3'h0, state, storedEventLed, buzzer, rmOnline, 1'b0, bridgeSel};
			default: rdMux = 32'h00000000;
		endcase
	end

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		next_ctrl = ctrl;
		next_active = active;
		next_prio = prio;
		next_prioEn = prioEn;
		next_holdBk = holdBk;
		next_holdRs = holdRs;
		next_addr = addr;
		next_state = state;
		next_bridge = bridgeSel;
		next_online = rmOnline;
		next_cnt = cnt;
		err = 1'b0;
		next_prdata = (psel & ~penable) ? rdMux : prdata;
		// Register writes from the permitted source only, except the panel setting the remote bit in remote mode.
		if (wr) begin
			case (paddr)
				A_CTRL: begin
					if (!srcOk) begin
						err = 1'b1;
						if (panelAccess) begin
							next_ctrl.remote = pwdata[1];
						end
					end else if (pwdata[5:4] == SWM_BAD || pwdata[10:8] > BAUD_MAX) begin
						err = 1'b1;
					end else begin
						next_ctrl = rsw_ctrl_t'(pwdata[11:0]);
					end
				end
				A_ACT: begin
					if (srcOk) begin
						next_active = pwdata[NSLOT-1:0];
					end else begin
						err = 1'b1;
					end
				end
				A_SEL: begin
					if (!srcOk || rmOnline && (ctrl.autoOn || pwdata[SEL_ONL] || pwdata[SEL_STEP]
						|| pwdata[3:0] != bridgeSel) || state != ST_IDLE && state != ST_ONL) begin
						err = 1'b1;
					end else if (ctrl.autoOn && pwdata[SEL_ONL]) begin
						err = 1'b1;
					end else if (pwdata[SEL_STEP]) begin
						next_bridge = nextAct(active, bridgeSel);
					end else if (pwdata[3:0] >= 4'(NSLOT) || !active[pwdata[3:0]]) begin
						err = 1'b1;
					end else begin
						next_bridge = pwdata[3:0];
						if (!ctrl.autoOn) begin
							next_online = pwdata[SEL_ONL];
							next_state = pwdata[SEL_ONL] ? ST_ONL : ST_IDLE;
						end
					end
				end
				A_PRIO: begin
					if (!srcOk || pwdata[3:0] >= 4'(NSLOT) || !active[pwdata[3:0]]) begin
						err = 1'b1;
					end else begin
						next_prio = pwdata[3:0];
						next_prioEn = pwdata[PRIO_EN];
					end
				end
				A_HOLD: begin
					if (!srcOk || wBk < HOLD_MIN || wBk > HOLD_MAX || wRs < HOLD_MIN || wRs > HOLD_MAX) begin
						err = 1'b1;
					end else begin
						next_holdBk = wBk;
						next_holdRs = wRs;
					end
				end
				A_ADDR: begin
					if (!srcOk || ctrl.rs232) begin
						err = 1'b1;
					end else begin
						next_addr = pwdata[15:0];
					end
				end
				default: err = 1'b1;
			endcase
		end else if (psel && penable && paddr > A_STAT) begin
			err = 1'b1;
		end
		// Switchover sequencing; only the auto mode moves on faults.
		case (state)
			ST_IDLE: begin
				if (!active[bridgeSel] && |active) begin
					next_bridge = lowest(active);
				end else if (ctrl.autoOn && |eff) begin
					next_bridge = (prioEn && eff[prio]) ? prio : lowest(eff);
					next_state = ST_CHK;
				end
			end
			ST_CHK: begin
				if (!ctrl.autoOn || !eff[bridgeSel]) begin
					next_state = ST_IDLE;
				end else if (!rmFault) begin
					next_state = ST_BKH;
					next_cnt = holdBk;
				end
			end
			ST_BKH: begin
				if (!ctrl.autoOn || !eff[bridgeSel] || rmFault) begin
					next_state = ST_IDLE;
				end else if (tick) begin
					if (cnt == HOLD_MIN) begin
						next_online = 1'b1;
						next_state = ST_ONL;
					end else begin
						next_cnt = cnt - HOLD_MIN;
					end
				end
			end
			ST_ONL, ST_RSH: begin
				if (!ctrl.autoOn) begin
					// Manual mode keeps what the register write chose; a pending restore is dropped.
					if (state == ST_RSH) begin
						next_state = ST_ONL;
					end
				end else if (prioEn && prio != bridgeSel && eff[prio]) begin
					next_online = 1'b0;
					next_bridge = prio;
					next_state = ST_CHK;
				end else if (eff[bridgeSel] || !(|others)) begin
					next_state = ST_ONL;
				end else if (state == ST_ONL) begin
					next_state = ST_RSH;
					next_cnt = holdRs;
				end else if (tick) begin
					if (cnt == HOLD_MIN) begin
						next_online = 1'b0;
						next_state = ST_IDLE;
					end else begin
						next_cnt = cnt - HOLD_MIN;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
		next_load = next_bridge != bridgeSel;
		next_rmCfg = next_load ? cfgMem[next_bridge] : rmCfg;
		// One log entry per cycle; pending new faults follow on later cycles.
		next_logValid = |newF;
		next_logSlot = lowest(newF);
		next_logKind = {mdm.rx[next_logSlot] & ~ctrl.modemMask[1], mdm.tx[next_logSlot] & ~ctrl.modemMask[0]};
		next_effPrev = (effPrev & eff) | (next_logValid ? NSLOT'(1) << next_logSlot : '0);
		next_buzzer = (ctrl.audio[0] & swAlm) | (ctrl.audio[1] & mdmAlm);
		next_blink = ctrl.autoOn ? 1'b0 : storedEventLed ^ tick;
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (learnValid && learnSlot < 4'(NSLOT) && active[learnSlot]) begin
			cfgMem[learnSlot] <= learnCfg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl <= rsw_ctrl_t'({1'b0, BAUD_RST, 8'h00});
			active <= '0;
			prio <= 4'h0;
			prioEn <= 1'b0;
			holdBk <= HOLD_BK_RST;
			holdRs <= HOLD_RS_RST;
			addr <= 16'h0000;
			state <= ST_IDLE;
			bridgeSel <= 4'h0;
			rmOnline <= 1'b0;
			cnt <= 7'h00;
			rmLoad <= 1'b0;
			rmCfg <= 32'h00000000;
			prdata <= 32'h00000000;
			effPrev <= '0;
			logValid <= 1'b0;
			logSlot <= 4'h0;
			logKind <= 2'h0;
			buzzer <= 1'b0;
			storedEventLed <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			active <= next_active;
			prio <= next_prio;
			prioEn <= next_prioEn;
			holdBk <= next_holdBk;
			holdRs <= next_holdRs;
			addr <= next_addr;
			state <= next_state;
			bridgeSel <= next_bridge;
			rmOnline <= next_online;
			cnt <= next_cnt;
			rmLoad <= next_load;
			rmCfg <= next_rmCfg;
			prdata <= next_prdata;
			effPrev <= next_effPrev;
			logValid <= next_logValid;
			logSlot <= next_logSlot;
			logKind <= next_logKind;
			buzzer <= next_buzzer;
			storedEventLed <= next_blink;
		end
	end

	assign pslverr = err;
	assign alarmRelay = buzzer;
	assign baudSel = ctrl.baud;
	assign busAddr = ctrl.rs232 ? 16'h0000 : addr;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	AST_LOCAL_REFUSE: assert property (wr && !ctrl.remote && !panelAccess |-> pslverr)
		else $error("remote write accepted in local mode");
	AST_REMOTE_REFUSE: assert property (wr && ctrl.remote && panelAccess && paddr != A_STAT
		|=> $stable(active) && $stable(holdBk))
		else $error("panel write changed configuration in remote mode");
	AST_STEP_ACTIVE: assert property (wr && paddr == A_SEL && pwdata[SEL_STEP] && !pslverr && |active
		|=> active[bridgeSel])
		else $error("step landed on inactive slot");
	AST_AUTO_BACKUP: assert property (wr && paddr == A_SEL && ctrl.autoOn && pwdata[SEL_ONL] |-> pslverr)
		else $error("backup selection accepted in auto mode");
	AST_ONLINE_LOCK: assert property (rmOnline && ctrl.autoOn && wr && paddr == A_SEL |=> $stable(bridgeSel))
		else $error("bridge changed while spare online");
	AST_LOAD_ON_BRIDGE: assert property (bridgeSel != $past(bridgeSel) |-> rmLoad)
		else $error("bridge change without configuration load");
	AST_MANUAL_NOSWITCH: assert property (!ctrl.autoOn && !wr |=> $stable(rmOnline))
		else $error("online state moved in manual mode");
	AST_BLINK_AUTO: assert property (ctrl.autoOn [*2] |-> !storedEventLed)
		else $error("stored-event blink in auto mode");
	AST_HOLD_RANGE: assert property (holdBk >= HOLD_MIN && holdBk <= HOLD_MAX && holdRs >= HOLD_MIN
		&& holdRs <= HOLD_MAX)
		else $error("holdoff out of range");
	AST_BACKUP_HOLD: assert property ($rose(rmOnline) && $past(ctrl.autoOn)
		|-> $past(state == ST_BKH && tick && cnt == HOLD_MIN))
		else $error("auto backup without holdoff expiry");
	AST_SW_MASK: assert property (ctrl.swMask != SWM_BAD)
		else $error("both supply units masked");
	AST_RS232_ADDR: assert property (ctrl.rs232 |-> busAddr == 16'h0000 && !(wr && paddr == A_ADDR && !pslverr))
		else $error("bus address not forced to zero");

	COV_AUTO_BACKUP: cover property ($rose(rmOnline) && ctrl.autoOn);
	COV_RESTORE: cover property (state == ST_RSH ##1 state == ST_IDLE);
	COV_PRIO: cover property (state == ST_ONL ##1 state == ST_CHK);
endmodule

// [inc/rsw_pkg.sv]
// Shared constants, layouts and types of the redundancy switchover controller.
package rsw_pkg;
	localparam int NSLOT = 10;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_ACT  = 8'h04;
	localparam logic [7:0] A_SEL  = 8'h08;
	localparam logic [7:0] A_PRIO = 8'h0c;
	localparam logic [7:0] A_HOLD = 8'h10;
	localparam logic [7:0] A_ADDR = 8'h14;
	localparam logic [7:0] A_STAT = 8'h18;
	localparam int SEL_ONL  = 8;
	localparam int SEL_STEP = 9;
	localparam int PRIO_EN  = 4;
	localparam int HOLD_RS  = 8;
	localparam logic [6:0] HOLD_MIN = 7'h01;
	localparam logic [6:0] HOLD_MAX = 7'h63;
	localparam logic [6:0] HOLD_BK_RST = 7'h05;
	localparam logic [6:0] HOLD_RS_RST = 7'h0a;
	localparam logic [2:0] BAUD_MAX = 3'h5;
	localparam logic [2:0] BAUD_RST = 3'h4;
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_S = 1;
	localparam int TICK_CYC = TICK_S * CLK_HZ;
	localparam logic [1:0] MM_TX = 2'h1;
	localparam logic [1:0] MM_RX = 2'h2;
	localparam logic [1:0] SWM_A = 2'h1;
	localparam logic [1:0] SWM_B = 2'h2;
	localparam logic [1:0] SWM_BAD = 2'h3;

	typedef struct packed {
		logic       rs232;
		logic [2:0] baud;
		logic [1:0] audio;
		logic [1:0] swMask;
		logic [1:0] modemMask;
		logic       remote;
		logic       autoOn;
	} rsw_ctrl_t;

	typedef struct packed {
		logic [NSLOT-1:0] alarm;
		logic [NSLOT-1:0] rx;
		logic [NSLOT-1:0] tx;
	} rsw_mdm_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_CHK  = 5'h02,
		ST_BKH  = 5'h04,
		ST_ONL  = 5'h08,
		ST_RSH  = 5'h10
	} rsw_state_t;
endpackage
